// [ivp_unit.sv]
// interrupt vector and priority unit: request gathering and arbitration
`timescale 1ns/1ps
// Contract
// - level-3 vectors: reset 00, stack 02, illegal 04, debug 06, trap 08, nmi 0A.
// - level-3 sources unmaskable, served reset, stack, illegal, debug, trap, nmi.
// - external A, B, D maskable, levels 0-2, vectors 10/12/16, A over B over D.
// - dma channel n at 18 plus 2n; lower channel wins; dma above serial ports.
// - audio port vectors 30..3E in receive then transmit order.
// - audio tie order: rx exc, rx even, rx, rx last, tx exc, tx last, tx even, tx.
// - host port vectors 40, 42, 44, 48, 4A, 4C; 46 and 4E unused.
// - host tie order: bus, overrun, underrun, full, tx, rx not empty last.
// - core mask 00 blocks none, 01 level 0, 10 levels 0-1, 11 levels 0-2.
// - levels come from core and peripheral priority registers.

module ivp_unit
(
  input  wire logic                      core_clk,
  input  wire logic                      resetn,
  input  wire logic                      hw_reset_req,
  input  wire logic                      stack_err_req,
  input  wire logic                      illegal_req,
  input  wire logic                      debug_req,
  input  wire logic                      trap_req,
  input  wire logic                      nmi_pin,
  input  wire logic                      ext_request_a,
  input  wire logic                      ext_request_b,
  input  wire logic                      ext_request_d,
  input  wire logic [5:0]                dma_req,
  input  wire logic [7:0]                audio_serial_port_req,
  input  wire logic [5:0]                host_serial_port_req,
  input  wire logic [5:0]                core_priority_reg,
  input  wire logic [5:0]                periph_priority_reg,
  input  wire logic [1:0]                core_mask,
  input  wire logic [ivp_pkg::ADDR_W-1:0] vector_base,
  output logic                           irq_valid,
  output logic [1:0]                     priority_level,
  output logic [7:0]                     irq_offset,
  output logic [ivp_pkg::ADDR_W-1:0]     irq_vector
);

  // ==========================================================
  // state
  typedef struct packed
  {
    logic [3:0]                  meta;
    logic [3:0]                  sync;
    logic                        valid;
    logic [1:0]                  level;
    logic [7:0]                  off;
    logic [ivp_pkg::ADDR_W-1:0]  vector;
  } ivp_state_t;

  ivp_state_t s;
  ivp_state_t next_s;

  // ==========================================================
  // request and level tables in service order
  logic [ivp_pkg::NUM_SRC-1:0] pend;
  logic [1:0]                  code [ivp_pkg::NUM_SRC];

  // priority code per group: 00 disabled, 01..11 level 0..2
  function automatic logic [1:0] grp_code(input logic [5:0] reg_v, input int g);
    grp_code = reg_v[2*g +: 2];
  endfunction

  always_comb
  begin
    pend = {host_serial_port_req[2], host_serial_port_req[0],
            host_serial_port_req[3], host_serial_port_req[1],
            host_serial_port_req[4], host_serial_port_req[5],
            audio_serial_port_req[4], audio_serial_port_req[5],
            audio_serial_port_req[7], audio_serial_port_req[6],
            audio_serial_port_req[3], audio_serial_port_req[0],
            audio_serial_port_req[1], audio_serial_port_req[2],
            dma_req[5], dma_req[4], dma_req[3], dma_req[2], dma_req[1], dma_req[0],
            s.sync[3], s.sync[2], s.sync[1],
            s.sync[0], trap_req, debug_req, illegal_req, stack_err_req,
            hw_reset_req};
    for (int i = 0; i < ivp_pkg::NUM_SRC; i++)
    begin
      if (i < 6)
        code[i] = 2'h3;
      else if (i < 9)
        code[i] = grp_code(core_priority_reg, i - 6);
      else if (i < 15)
        code[i] = grp_code(periph_priority_reg, 0);
      else if (i < 23)
        code[i] = grp_code(periph_priority_reg, 1);
      else
        code[i] = grp_code(periph_priority_reg, 2);
    end
  end

  // ==========================================================
  // arbitration
  logic       found;
  logic [1:0] best_lvl;
  logic [7:0] best_off;

  always_comb
  begin
    logic [1:0] lv;
    logic       ok;
    lv       = 2'h0;
    ok       = 1'b0;
    found    = 1'b0;
    best_lvl = 2'h0;
    best_off = 8'h00;
    for (int i = 0; i < ivp_pkg::NUM_SRC; i++)
    begin
      lv = (i < 6) ? ivp_pkg::LVL_NMI : code[i] - 2'h1;
      ok = pend[i] && (code[i] != ivp_pkg::CODE_DISABLE)
           && ((i < 6) || (lv >= core_mask));
      if (ok && (!found || lv > best_lvl))
      begin
        found    = 1'b1;
        best_lvl = lv;
        best_off = ivp_pkg::SRC_OFF[i];
      end
    end
  end

  // ==========================================================
  // next state
  always_comb
  begin
    next_s        = s;
    next_s.meta   = {ext_request_d, ext_request_b, ext_request_a, nmi_pin};
    next_s.sync   = s.meta;
    next_s.valid  = found;
    next_s.level  = found ? best_lvl : 2'h0;
    next_s.off    = found ? best_off : 8'h00;
    next_s.vector = found ? {vector_base[ivp_pkg::ADDR_W-1:8], best_off} : '0;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      s <= '0;
    else
      s <= next_s;
  end

  assign irq_valid      = s.valid;
  assign priority_level = s.level;
  assign irq_offset     = s.off;
  assign irq_vector     = s.vector;

  // ==========================================================
  // checks
  property p_reset_vec;
    @(posedge core_clk) disable iff (!resetn)
      hw_reset_req |=> irq_valid && irq_offset == ivp_pkg::OFF_HW_RESET
                       && priority_level == ivp_pkg::LVL_NMI;
  endproperty
  a_reset_vec: assert property (p_reset_vec) else $error("reset vector not taken");

  property p_l3_order;
    @(posedge core_clk) disable iff (!resetn)
      stack_err_req && !hw_reset_req |=> irq_offset == ivp_pkg::OFF_STACK;
  endproperty
  a_l3_order: assert property (p_l3_order) else $error("level-3 order wrong");

  property p_mask;
    @(posedge core_clk) disable iff (!resetn)
      irq_valid && priority_level != ivp_pkg::LVL_NMI |-> priority_level >= $past(core_mask);
  endproperty
  a_mask: assert property (p_mask) else $error("masked level granted");

  property p_resv;
    @(posedge core_clk) disable iff (!resetn)
      irq_valid |-> irq_offset[0] == 1'b0 && irq_offset <= ivp_pkg::OFF_LAST
                    && !(irq_offset >= ivp_pkg::OFF_RSV_LO && irq_offset <= ivp_pkg::OFF_RSV_HI);
  endproperty
  a_resv: assert property (p_resv) else $error("reserved vector issued");

  property p_disabled;
    @(posedge core_clk) disable iff (!resetn)
      irq_valid && irq_offset == ivp_pkg::OFF_EXT_A |-> $past(core_priority_reg[1:0]) != 2'h0;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled source granted");

  property p_ext_order;
    @(posedge core_clk) disable iff (!resetn)
      irq_valid && irq_offset == ivp_pkg::OFF_EXT_B
      |-> !($past(s.sync[1]) && $past(core_priority_reg[1:0]) == $past(core_priority_reg[3:2]));
  endproperty
  a_ext_order: assert property (p_ext_order) else $error("B beat equal A");

  property p_dma_order;
    @(posedge core_clk) disable iff (!resetn)
      irq_valid && irq_offset == ivp_pkg::OFF_DMA1 |-> !$past(dma_req[0]);
  endproperty
  a_dma_order: assert property (p_dma_order) else $error("dma order wrong");

  property p_audio_order;
    @(posedge core_clk) disable iff (!resetn)
      irq_valid && irq_offset == ivp_pkg::OFF_AUD_RX
      |-> !$past(audio_serial_port_req[1]) && !$past(audio_serial_port_req[2])
          && ($past(dma_req) == 6'h00
              || $past(periph_priority_reg[1:0]) < $past(periph_priority_reg[3:2]));
  endproperty
  a_audio_order: assert property (p_audio_order) else $error("audio order wrong");

  property p_host_order;
    @(posedge core_clk) disable iff (!resetn)
      irq_valid && irq_offset == ivp_pkg::OFF_HOST_RXNE
      |-> ($past(host_serial_port_req) & 6'h3B) == 6'h00
          && ($past(audio_serial_port_req) == 8'h00
              || $past(periph_priority_reg[3:2]) < $past(periph_priority_reg[5:4]));
  endproperty
  a_host_order: assert property (p_host_order) else $error("host order wrong");

  property p_l3_unmasked;
    @(posedge core_clk) disable iff (!resetn)
      hw_reset_req || stack_err_req || illegal_req || debug_req || trap_req
      |=> irq_valid && priority_level == ivp_pkg::LVL_NMI;
  endproperty
  a_l3_unmasked: assert property (p_l3_unmasked) else $error("level-3 source masked");

  property p_vec_base;
    @(posedge core_clk) disable iff (!resetn)
      irq_valid |-> irq_vector == {$past(vector_base[ivp_pkg::ADDR_W-1:8]), irq_offset};
  endproperty
  a_vec_base: assert property (p_vec_base) else $error("vector not on base");

endmodule

// [ivp_pkg.sv]
// constants for the interrupt vector and priority unit
package ivp_pkg;

  // ==========================================================
  // sizes
  localparam int NUM_SRC   = 29;
  localparam int NUM_DMA   = 6;
  localparam int NUM_AUDIO = 8;
  localparam int NUM_HOST  = 6;
  localparam int ADDR_W    = 24;

  // ==========================================================
  // levels and priority codes
  localparam logic [1:0] LVL_NMI      = 2'h3;
  localparam logic [1:0] CODE_DISABLE = 2'h0;

  // ==========================================================
  // vector offsets, listed in service order within a level
  localparam logic [7:0] OFF_HW_RESET = 8'h00;
  localparam logic [7:0] OFF_STACK    = 8'h02;
  localparam logic [7:0] OFF_EXT_A    = 8'h10;
  localparam logic [7:0] OFF_EXT_B    = 8'h12;
  localparam logic [7:0] OFF_DMA1     = 8'h1A;
  localparam logic [7:0] OFF_AUD_RX   = 8'h30;
  localparam logic [7:0] OFF_HOST_RXNE = 8'h44;
  localparam logic [7:0] OFF_RSV_LO   = 8'h24;
  localparam logic [7:0] OFF_RSV_HI   = 8'h2E;
  localparam logic [7:0] OFF_LAST     = 8'h4C;

  localparam logic [7:0] SRC_OFF [NUM_SRC] = '{
    8'h00, 8'h02, 8'h04, 8'h06, 8'h08, 8'h0A,
    8'h10, 8'h12, 8'h16,
    8'h18, 8'h1A, 8'h1C, 8'h1E, 8'h20, 8'h22,
    8'h34, 8'h32, 8'h30, 8'h36, 8'h3C, 8'h3E, 8'h3A, 8'h38,
    8'h4C, 8'h4A, 8'h42, 8'h48, 8'h40, 8'h44
  };

endpackage

// [ivp_core_model.sv]
// core sequencer model: applies the interrupt mask and fetches granted vectors
`timescale 1ns/1ps
module ivp_core_model
(
  input  wire logic                      core_clk,
  input  wire logic                      resetn,
  input  wire logic                      irq_valid,
  input  wire logic [ivp_pkg::ADDR_W-1:0] irq_vector,
  input  wire logic [1:0]                mask_set,
  output logic [1:0]                     core_mask,
  output logic [ivp_pkg::ADDR_W-1:0]     fetch_addr
);
  // ==========================================================
  // mask follows the request one cycle late; fetch on grant
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      core_mask  <= 2'h0;
      fetch_addr <= 24'h000000;
    end
    else
    begin
      core_mask <= mask_set;
      if (irq_valid)
        fetch_addr <= irq_vector;
    end
  end
endmodule

// [testbench.sv]
// self-checking bench for the interrupt vector and priority unit
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module testbench;
  // ==========================================================
  // request word: host, audio, dma, d, b, a, nmi, level-3 sources
  typedef struct packed {
    logic [28:0] req;
    logic [5:0]  cpr;
    logic [5:0]  ppr;
    logic [1:0]  msk;
    logic        v;
    logic [1:0]  lvl;
    logic [7:0]  off;
  } ivp_row_t;
  localparam ivp_row_t ROWS [31] = '{
    '{29'h3,6'h15,6'h15,2'h0,1'h1,2'h3,8'h00},
    '{29'h1A,6'h15,6'h15,2'h0,1'h1,2'h3,8'h02},
    '{29'hC,6'h15,6'h15,2'h0,1'h1,2'h3,8'h04},
    '{29'h18,6'h15,6'h15,2'h0,1'h1,2'h3,8'h06},
    '{29'h30,6'h15,6'h15,2'h3,1'h1,2'h3,8'h08},
    '{29'h1E0,6'h15,6'h15,2'h3,1'h1,2'h3,8'h0A},
    '{29'h7FC0,6'h15,6'h15,2'h0,1'h1,2'h0,8'h10},
    '{29'h180,6'h15,6'h15,2'h0,1'h1,2'h0,8'h12},
    '{29'h300,6'h15,6'h15,2'h0,1'h1,2'h0,8'h16},
    '{29'h7FFC00,6'h15,6'h15,2'h0,1'h1,2'h0,8'h1A},
    '{29'h1FFFC000,6'h15,6'h15,2'h0,1'h1,2'h0,8'h22},
    '{29'h1FFF8000,6'h15,6'h15,2'h0,1'h1,2'h0,8'h34},
    '{29'h58000,6'h15,6'h15,2'h0,1'h1,2'h0,8'h32},
    '{29'h48000,6'h15,6'h15,2'h0,1'h1,2'h0,8'h30},
    '{29'h40000,6'h15,6'h15,2'h0,1'h1,2'h0,8'h36},
    '{29'h780000,6'h15,6'h15,2'h0,1'h1,2'h0,8'h3C},
    '{29'h500000,6'h15,6'h15,2'h0,1'h1,2'h0,8'h3E},
    '{29'h180000,6'h15,6'h15,2'h0,1'h1,2'h0,8'h3A},
    '{29'h80000,6'h15,6'h15,2'h0,1'h1,2'h0,8'h38},
    '{29'h1F800000,6'h15,6'h15,2'h0,1'h1,2'h0,8'h4C},
    '{29'hF800000,6'h15,6'h15,2'h0,1'h1,2'h0,8'h4A},
    '{29'h7800000,6'h15,6'h15,2'h0,1'h1,2'h0,8'h42},
    '{29'h6800000,6'h15,6'h15,2'h0,1'h1,2'h0,8'h48},
    '{29'h2800000,6'h15,6'h15,2'h0,1'h1,2'h0,8'h40},
    '{29'h2000000,6'h15,6'h15,2'h0,1'h1,2'h0,8'h44},
    '{29'h2000240,6'h01,6'h30,2'h0,1'h1,2'h2,8'h44},
    '{29'h40,6'h01,6'h00,2'h1,1'h0,2'h0,8'h00},
    '{29'h40,6'h02,6'h00,2'h1,1'h1,2'h1,8'h10},
    '{29'h40,6'h02,6'h00,2'h2,1'h0,2'h0,8'h00},
    '{29'h8200,6'h15,6'h04,2'h0,1'h1,2'h0,8'h30},
    '{29'hC0,6'h0D,6'h15,2'h0,1'h1,2'h2,8'h12}
  };
  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [28:0] req = '0;
  logic [5:0]  cpr = '0;
  logic [5:0]  ppr = '0;
  logic [1:0]  mask_set = '0;
  logic [23:0] base = 24'hABCDEF;
  logic        irq_valid;
  logic [1:0]  lvl;
  logic [1:0]  core_mask;
  logic [7:0]  off;
  logic [23:0] vec;
  logic [23:0] fetch_addr;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  always #2.5 core_clk = ~core_clk;
  ivp_unit ivp_unit_inst (.core_clk(core_clk), .resetn(resetn), .hw_reset_req(req[0]),
    .stack_err_req(req[1]), .illegal_req(req[2]), .debug_req(req[3]), .trap_req(req[4]),
    .nmi_pin(req[5]), .ext_request_a(req[6]), .ext_request_b(req[7]), .ext_request_d(req[8]),
    .dma_req(req[14:9]), .audio_serial_port_req(req[22:15]), .host_serial_port_req(req[28:23]),
    .core_priority_reg(cpr), .periph_priority_reg(ppr), .core_mask(core_mask),
    .vector_base(base), .irq_valid(irq_valid), .priority_level(lvl), .irq_offset(off),
    .irq_vector(vec));
  ivp_core_model ivp_core_model_inst (.core_clk(core_clk), .resetn(resetn),
    .irq_valid(irq_valid), .irq_vector(vec), .mask_set(mask_set), .core_mask(core_mask),
    .fetch_addr(fetch_addr));
  // ==========================================================
  // checks and closing
  task automatic chk(input logic v, input logic [1:0] l, input logic [7:0] o);
    `CHK({irq_valid, lvl, off, vec}, {v, l, o, v ? {base[23:8], o} : 24'h000000})
  endtask
  task automatic stop_test;
    if (miscompares == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 400)
    begin
      miscompares++;
      stop_test();
    end
  end
  // ==========================================================
  // table loop, then latency and reset cases
  initial
  begin
    repeat (2) @(negedge core_clk);
    resetn = 1'b1;
    foreach (ROWS[i])
    begin
      {req, cpr, ppr, mask_set} = {ROWS[i].req, ROWS[i].cpr, ROWS[i].ppr, ROWS[i].msk};
      repeat (4) @(negedge core_clk);
      chk(ROWS[i].v, ROWS[i].lvl, ROWS[i].off);
      if (ROWS[i].v)
        `CHK(fetch_addr, {base[23:8], ROWS[i].off})
    end
    {req, cpr, ppr, mask_set} = {29'h200, 6'h00, 6'h01, 2'h0};
    @(negedge core_clk);
    chk(1'b1, 2'h0, 8'h18);
    req = 29'h0;
    @(negedge core_clk);
    chk(1'b0, 2'h0, 8'h00);
    {req, cpr} = {29'h40, 6'h01};
    repeat (2) @(negedge core_clk);
    chk(1'b0, 2'h0, 8'h00);
    @(negedge core_clk);
    chk(1'b1, 2'h0, 8'h10);
    resetn = 1'b0;
    #1 chk(1'b0, 2'h0, 8'h00);
    @(negedge core_clk);
    resetn = 1'b1;
    repeat (4) @(negedge core_clk);
    chk(1'b1, 2'h0, 8'h10);
    stop_test();
  end
endmodule
